/* logic/tcp_pkg.sv */
// shared constants and types of the timer, clock and port register bank
package tcp_pkg;

	// =========================================================
	// register offsets
	localparam logic [7:0] TIMER0_COUNT_LOW_ADDR   = 8'h8a;
	localparam logic [7:0] TIMER1_COUNT_LOW_ADDR   = 8'h8b;
	localparam logic [7:0] TIMER0_COUNT_HIGH_ADDR  = 8'h8c;
	localparam logic [7:0] TIMER1_COUNT_HIGH_ADDR  = 8'h8d;
	localparam logic [7:0] PRESCALE_CTRL_ADDR      = 8'h8e;
	localparam logic [7:0] FLASH_WRITE_SELECT_ADDR = 8'h8f;
	localparam logic [7:0] PORT1_LATCH_ADDR        = 8'h90;
	localparam logic [7:0] EXT_IRQ_FLAGS_ADDR      = 8'h91;

	// =========================================================
	// reset values
	localparam logic [7:0] TIMER_COUNT_RESET  = 8'h00;
	localparam logic [5:0] PRESCALE_RESET     = 6'h01;
	localparam logic       FLASH_WRITE_RESET  = 1'b0;
	localparam logic [7:0] PORT1_LATCH_RESET  = 8'hff;
	localparam logic [3:0] IRQ_FLAGS_RESET    = 4'h0;
	localparam logic [3:0] IRQ_FLAGS_LOW_BITS = 4'h8;

	// =========================================================
	// field positions
	localparam int TIMER2_FAST_BIT   = 5;
	localparam int TIMER1_FAST_BIT   = 4;
	localparam int TIMER0_FAST_BIT   = 3;
	localparam int STRETCH_MSB       = 2;
	localparam int FLASH_WRITE_BIT   = 0;
	localparam int PIN_TIMER2_COUNT  = 0;
	localparam int PIN_TIMER2_TRIG   = 1;
	localparam int PIN_SLAVE_SELECT  = 4;
	localparam int PIN_EXT_IRQ2      = 4;
	localparam int PIN_EXT_IRQ3      = 5;
	localparam int PIN_EXT_IRQ4      = 6;
	localparam int PIN_EXT_IRQ5      = 7;

	// =========================================================
	// timing counts in system clocks and instruction cycles
	localparam logic [3:0] DIV_SLOW_CLKS     = 4'd12;
	localparam logic [1:0] DIV_FAST_LAST     = 2'd3;
	localparam logic [5:0] INSTR_CYCLE_CLKS  = 6'd4;
	localparam logic [5:0] XMOVE_BASE_CYCLES = 6'd2;
	localparam logic [5:0] STROBE_BASE_CLKS  = 6'd2;
	localparam logic [5:0] STROBE_UNIT_CLKS  = 6'd4;
	localparam logic [5:0] XMOVE_SETUP_CLKS  = 6'd4;

	// =========================================================
	// types
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tcp_sfr_req_type;

	typedef enum logic [3:0] {
		XMOVE_IDLE   = 4'b0001,
		XMOVE_SETUP  = 4'b0010,
		XMOVE_STROBE = 4'b0100,
		XMOVE_HOLD   = 4'b1000
	} tcp_xmove_state_type;

	typedef struct packed {
		logic [15:0]         t0;
		logic [15:0]         t1;
		logic [5:0]          clk_ctrl;
		logic                flash_sel;
		logic [7:0]          latch;
		logic [3:0]          flags;
		logic [3:0]          div;
		logic [7:0]          rdata;
		tcp_xmove_state_type xstate;
		logic [5:0]          xcnt;
		logic [5:0]          xlast;
		logic [5:0]          xstrobe_end;
		logic                xdone;
	} tcp_state_type;

endpackage : tcp_pkg

/* logic/tcp_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
module tcp_pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_stable,
	output logic      [WIDTH-1:0] pin_rise,
	output logic      [WIDTH-1:0] pin_fall
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] rise;
		logic [WIDTH-1:0] fall;
	} tcp_sync_state_type;

	tcp_sync_state_type sync_reg;
	tcp_sync_state_type sync_next;

	// =========================================================
	// filter and edge detect
	always_comb begin
		sync_next = sync_reg;
		sync_next.s1 = pin_async;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (sync_reg.s2[i] == sync_reg.s3[i]) begin // RULE22
				sync_next.stable[i] = sync_reg.s3[i];
			end
		end
		sync_next.rise = sync_next.stable & ~sync_reg.stable; // RULE22
		sync_next.fall = ~sync_next.stable & sync_reg.stable; // RULE22
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync_reg <= '{default: '1, rise: '0, fall: '0};
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign pin_stable = sync_reg.stable;
	assign pin_rise   = sync_reg.rise;
	assign pin_fall   = sync_reg.fall;

endmodule : tcp_pin_sync

/* logic/tcp_sfr_bank.sv */
// timer count, clock control, flash write, port 1 and edge flag registers
//
// Contract
// RULE1: timer 0 count as low and high bytes
// RULE2: timer 1 count bytes at 8Bh/8Dh, reset zero
// RULE3: timer 2 select bit picks divide 12 or 4
// RULE4: timer 2 select ignored in baud/clock-out mode
// RULE5: timer 1 select bit picks divide 12 or 4
// RULE6: timer 0 select bit picks divide 12 or 4
// RULE7: selects leave instruction timing; clear gives twelve
// RULE8: stretch field sets move length and strobe
// RULE9: clock control resets 01h, bits 7-6 zero
// RULE10: stretch lengthens only the external strobe
// RULE11: on-chip data moves always take two cycles
// RULE12: flash writes need select and no lock
// RULE13: port latches reset FFh; alternate needs 1
// RULE14: falling edges set flags 5 and 3
// RULE15: rising edges set flags 4 and 2
// RULE16: flags sticky; software write 1 requests interrupt
// RULE17: flag register resets 08h, low bits fixed
// RULE18: timer 2 input falling edge increments
// RULE19: trigger falling edge captures or reloads timer 2
// RULE20: slave select does not gate miso drive
// RULE21: count writes next clock, reads non-disturbing
// RULE22: pin edges synchronised and compared before flagging
module tcp_sfr_bank (
	input  wire logic                     clk_sys,
	input  wire logic                     srst,
	input  wire tcp_pkg::tcp_sfr_req_type sfr_req,
	output logic      [7:0]               sfr_rdata,
	input  wire logic                     timer0_count_update,
	input  wire logic [15:0]              timer0_count_in,
	input  wire logic                     timer1_count_update,
	input  wire logic [15:0]              timer1_count_in,
	output logic      [15:0]              timer0_count,
	output logic      [15:0]              timer1_count,
	output logic                          timer0_tick,
	output logic                          timer1_tick,
	output logic                          timer2_tick,
	input  wire logic                     timer2_baud_or_clkout,
	input  wire logic                     timer2_trigger_enable,
	input  wire logic                     timer2_autoreload_mode,
	output logic                          timer2_ext_increment,
	output logic                          timer2_capture,
	output logic                          timer2_reload,
	input  wire logic                     xmove_start,
	input  wire logic                     xmove_internal,
	output logic                          xmove_strobe,
	output logic                          xmove_busy,
	output logic                          xmove_done,
	input  wire logic                     program_memory_lock,
	input  wire logic                     reset_sector_lock,
	output logic                          flash_write_allow,
	input  wire logic [7:0]               port1_pin_in,
	output logic      [7:0]               port1_pin_out,
	output logic      [7:0]               port1_pin_oe,
	output logic      [7:0]               port1_latch,
	output logic                          spi_slave_select_n,
	output logic      [3:0]               ext_irq_flags
);

	// =========================================================
	// helpers

	// strobe width in clocks for a stretch setting
	function automatic logic [5:0] strobe_clks(input logic [2:0] sel);
		if (sel == 3'h0) begin
			strobe_clks = tcp_pkg::STROBE_BASE_CLKS;
		end else begin
			strobe_clks = 6'(tcp_pkg::STROBE_UNIT_CLKS * {3'h0, sel});
		end
	endfunction : strobe_clks

	// whole move length in clocks, minus one
	function automatic logic [5:0] move_last(input logic [2:0] sel);
		logic [5:0] cycles;
		cycles = tcp_pkg::XMOVE_BASE_CYCLES + {3'h0, sel};
		move_last = 6'(cycles * tcp_pkg::INSTR_CYCLE_CLKS - 6'd1);
	endfunction : move_last

	// merge a byte write into a 16-bit count
	function automatic logic [15:0] byte_write(input logic [15:0] cur,
			input logic hi_sel, input logic [7:0] data);
		byte_write = hi_sel ? {data, cur[7:0]} : {cur[15:8], data};
	endfunction : byte_write

	tcp_pkg::tcp_state_type st_reg;
	tcp_pkg::tcp_state_type st_next;

	logic [7:0] pin_stable;
	logic [7:0] pin_rise;
	logic [7:0] pin_fall;
	logic [7:0] alt_rise;
	logic [7:0] alt_fall;
	logic       tick_slow;
	logic       tick_fast;
	logic [2:0] stretch_sel;
	logic       wr;
	logic [3:0] edge_set;

	// =========================================================
	// pin synchroniser
	tcp_pin_sync #(
		.WIDTH (8)
	) u_pin_sync (
		.clk_sys    (clk_sys),
		.srst       (srst),
		.pin_async  (port1_pin_in),
		.pin_stable (pin_stable),
		.pin_rise   (pin_rise),
		.pin_fall   (pin_fall)
	);

	// alternate pin functions only see edges while the latch holds 1
	assign alt_rise = pin_rise & st_reg.latch; // RULE13
	assign alt_fall = pin_fall & st_reg.latch; // RULE13

	// this cycle's edges, kept apart so a clear cannot swallow a fresh one
	assign edge_set = {alt_fall[tcp_pkg::PIN_EXT_IRQ5],
		alt_rise[tcp_pkg::PIN_EXT_IRQ4], alt_fall[tcp_pkg::PIN_EXT_IRQ3],
		alt_rise[tcp_pkg::PIN_EXT_IRQ2]}; // RULE14 RULE15

	// =========================================================
	// prescale divider
	// free running on the system clock; instruction timing never uses it
	assign tick_slow = (st_reg.div == 4'(tcp_pkg::DIV_SLOW_CLKS - 4'd1));
	assign tick_fast = (st_reg.div[1:0] == tcp_pkg::DIV_FAST_LAST); // RULE7

	assign stretch_sel = st_reg.clk_ctrl[tcp_pkg::STRETCH_MSB:0];
	assign wr          = sfr_req.wr;

	// =========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.xdone = 1'b0;

		// divider
		if (tick_slow) begin
			st_next.div = 4'h0;
		end else begin
			st_next.div = st_reg.div + 4'h1;
		end

		// counting engine updates, then software bytes override
		if (timer0_count_update) begin
			st_next.t0 = timer0_count_in;
		end
		if (timer1_count_update) begin
			st_next.t1 = timer1_count_in;
		end

		// hardware edge flags
		if (alt_fall[tcp_pkg::PIN_EXT_IRQ3]) begin
			st_next.flags[1] = 1'b1; // RULE14
		end
		if (alt_fall[tcp_pkg::PIN_EXT_IRQ5]) begin
			st_next.flags[3] = 1'b1; // RULE14
		end
		if (alt_rise[tcp_pkg::PIN_EXT_IRQ2]) begin
			st_next.flags[0] = 1'b1; // RULE15
		end
		if (alt_rise[tcp_pkg::PIN_EXT_IRQ4]) begin
			st_next.flags[2] = 1'b1; // RULE15
		end

		// software writes
		if (wr) begin
			case (sfr_req.addr)
				tcp_pkg::TIMER0_COUNT_LOW_ADDR: begin
					st_next.t0 = byte_write(st_next.t0, 1'b0,
						sfr_req.wdata); // RULE1 RULE21
				end
				tcp_pkg::TIMER0_COUNT_HIGH_ADDR: begin
					st_next.t0 = byte_write(st_next.t0, 1'b1,
						sfr_req.wdata); // RULE1 RULE21
				end
				tcp_pkg::TIMER1_COUNT_LOW_ADDR: begin
					st_next.t1 = byte_write(st_next.t1, 1'b0,
						sfr_req.wdata); // RULE2 RULE21
				end
				tcp_pkg::TIMER1_COUNT_HIGH_ADDR: begin
					st_next.t1 = byte_write(st_next.t1, 1'b1,
						sfr_req.wdata); // RULE2 RULE21
				end
				tcp_pkg::PRESCALE_CTRL_ADDR: begin
					st_next.clk_ctrl = sfr_req.wdata[5:0]; // RULE9
				end
				tcp_pkg::FLASH_WRITE_SELECT_ADDR: begin
					st_next.flash_sel = sfr_req.wdata[tcp_pkg::FLASH_WRITE_BIT];
				end
				tcp_pkg::PORT1_LATCH_ADDR: begin
					st_next.latch = sfr_req.wdata;
				end
				tcp_pkg::EXT_IRQ_FLAGS_ADDR: begin
					// a hardware edge in the same cycle survives a clear
					st_next.flags = sfr_req.wdata[7:4]
						| edge_set; // RULE16
				end
				default: begin
				end
			endcase
		end

		// registered read data
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				tcp_pkg::TIMER0_COUNT_LOW_ADDR: begin
					st_next.rdata = st_reg.t0[7:0]; // RULE1 RULE21
				end
				tcp_pkg::TIMER0_COUNT_HIGH_ADDR: begin
					st_next.rdata = st_reg.t0[15:8]; // RULE1
				end
				tcp_pkg::TIMER1_COUNT_LOW_ADDR: begin
					st_next.rdata = st_reg.t1[7:0]; // RULE2
				end
				tcp_pkg::TIMER1_COUNT_HIGH_ADDR: begin
					st_next.rdata = st_reg.t1[15:8]; // RULE2
				end
				tcp_pkg::PRESCALE_CTRL_ADDR: begin
					st_next.rdata = {2'h0, st_reg.clk_ctrl}; // RULE9
				end
				tcp_pkg::FLASH_WRITE_SELECT_ADDR: begin
					st_next.rdata = {7'h00, st_reg.flash_sel};
				end
				tcp_pkg::PORT1_LATCH_ADDR: begin
					st_next.rdata = pin_stable;
				end
				tcp_pkg::EXT_IRQ_FLAGS_ADDR: begin
					st_next.rdata = {st_reg.flags,
						tcp_pkg::IRQ_FLAGS_LOW_BITS}; // RULE17
				end
				default: begin
					st_next.rdata = 8'h00;
				end
			endcase
		end

		// external data move sequencer
		// a start while busy is ignored; a move always runs to its end
		case (st_reg.xstate)
			tcp_pkg::XMOVE_IDLE: begin
				if (xmove_start) begin
					st_next.xstate = tcp_pkg::XMOVE_SETUP;
					st_next.xcnt   = 6'h00;
					if (xmove_internal) begin
						st_next.xlast = move_last(3'h0); // RULE11
						st_next.xstrobe_end = tcp_pkg::XMOVE_SETUP_CLKS;
					end else begin
						st_next.xlast = move_last(stretch_sel); // RULE8
						st_next.xstrobe_end = 6'(tcp_pkg::XMOVE_SETUP_CLKS
							+ strobe_clks(stretch_sel)); // RULE8 RULE10
					end
				end
			end
			tcp_pkg::XMOVE_SETUP: begin
				st_next.xcnt = st_reg.xcnt + 6'h01;
				if (st_next.xcnt == tcp_pkg::XMOVE_SETUP_CLKS) begin
					if (st_reg.xstrobe_end == tcp_pkg::XMOVE_SETUP_CLKS) begin
						st_next.xstate = tcp_pkg::XMOVE_HOLD; // RULE11
					end else begin
						st_next.xstate = tcp_pkg::XMOVE_STROBE;
					end
				end
			end
			tcp_pkg::XMOVE_STROBE: begin
				st_next.xcnt = st_reg.xcnt + 6'h01;
				if (st_next.xcnt == st_reg.xstrobe_end) begin
					st_next.xstate = tcp_pkg::XMOVE_HOLD; // RULE10
				end
			end
			tcp_pkg::XMOVE_HOLD: begin
				st_next.xcnt = st_reg.xcnt + 6'h01;
				if (st_reg.xcnt == st_reg.xlast) begin
					st_next.xstate = tcp_pkg::XMOVE_IDLE;
					st_next.xdone  = 1'b1;
				end
			end
			default: begin
				st_next.xstate = tcp_pkg::XMOVE_IDLE;
			end
		endcase
	end

	// =========================================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_reg.t0          <= {2{tcp_pkg::TIMER_COUNT_RESET}};
			st_reg.t1          <= {2{tcp_pkg::TIMER_COUNT_RESET}}; // RULE2
			st_reg.clk_ctrl    <= tcp_pkg::PRESCALE_RESET; // RULE9
			st_reg.flash_sel   <= tcp_pkg::FLASH_WRITE_RESET; // RULE12
			st_reg.latch       <= tcp_pkg::PORT1_LATCH_RESET; // RULE13
			st_reg.flags       <= tcp_pkg::IRQ_FLAGS_RESET; // RULE17
			st_reg.div         <= 4'h0;
			st_reg.rdata       <= 8'h00;
			st_reg.xstate      <= tcp_pkg::XMOVE_IDLE;
			st_reg.xcnt        <= 6'h00;
			st_reg.xlast       <= 6'h00;
			st_reg.xstrobe_end <= 6'h00;
			st_reg.xdone       <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// =========================================================
	// outputs
	assign sfr_rdata    = st_reg.rdata;
	assign timer0_count = st_reg.t0;
	assign timer1_count = st_reg.t1;

	assign timer0_tick = st_reg.clk_ctrl[tcp_pkg::TIMER0_FAST_BIT]
		? tick_fast : tick_slow; // RULE6 RULE7
	assign timer1_tick = st_reg.clk_ctrl[tcp_pkg::TIMER1_FAST_BIT]
		? tick_fast : tick_slow; // RULE5 RULE7
	// in baud or clock-out mode the engine takes its own clock
	assign timer2_tick = (st_reg.clk_ctrl[tcp_pkg::TIMER2_FAST_BIT]
		&& !timer2_baud_or_clkout) ? tick_fast : tick_slow; // RULE3 RULE4

	assign timer2_ext_increment = alt_fall[tcp_pkg::PIN_TIMER2_COUNT]; // RULE18
	assign timer2_capture = alt_fall[tcp_pkg::PIN_TIMER2_TRIG]
		&& timer2_trigger_enable && !timer2_autoreload_mode; // RULE19
	assign timer2_reload  = alt_fall[tcp_pkg::PIN_TIMER2_TRIG]
		&& timer2_trigger_enable && timer2_autoreload_mode; // RULE19

	assign xmove_strobe = (st_reg.xstate == tcp_pkg::XMOVE_STROBE); // RULE10
	assign xmove_busy   = (st_reg.xstate != tcp_pkg::XMOVE_IDLE);
	assign xmove_done   = st_reg.xdone;

	// locks override the select bit at once, with no register between
	assign flash_write_allow = st_reg.flash_sel && !program_memory_lock
		&& !reset_sector_lock; // RULE12

	// quasi-bidirectional: a latch bit of 0 pulls the pin low
	assign port1_pin_out = 8'h00;
	assign port1_pin_oe  = ~st_reg.latch; // RULE13
	assign port1_latch   = st_reg.latch;

	// only a select; miso drive stays with the spi block
	assign spi_slave_select_n = pin_stable[tcp_pkg::PIN_SLAVE_SELECT]; // RULE20

	assign ext_irq_flags = st_reg.flags; // RULE16

endmodule : tcp_sfr_bank

/* tb/tcp_sfr_bank_props.sv */
// assertions on the ports of the timer, clock and port register bank
module tcp_sfr_bank_props (
	input wire logic                     clk_sys,
	input wire logic                     srst,
	input wire tcp_pkg::tcp_sfr_req_type sfr_req,
	input wire logic [7:0]               sfr_rdata,
	input wire logic [15:0]              timer1_count,
	input wire logic                     timer2_trigger_enable,
	input wire logic                     timer2_autoreload_mode,
	input wire logic                     timer2_ext_increment,
	input wire logic                     timer2_capture,
	input wire logic                     xmove_start,
	input wire logic                     xmove_internal,
	input wire logic                     xmove_strobe,
	input wire logic                     xmove_busy,
	input wire logic                     xmove_done,
	input wire logic                     program_memory_lock,
	input wire logic                     flash_write_allow,
	input wire logic [7:0]               port1_pin_oe,
	input wire logic [7:0]               port1_latch,
	input wire logic [3:0]               ext_irq_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================================
	// bus, port and move properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic rd_ckc, rd_flg, wr_flg;
	assign rd_ckc = sfr_req.rd && sfr_req.addr == 8'h8e;
	assign rd_flg = sfr_req.rd && sfr_req.addr == 8'h91;
	assign wr_flg = sfr_req.wr && sfr_req.addr == 8'h91;
	sequence go_ext;
		xmove_start && !xmove_busy && !xmove_internal;
	endsequence
	sequence go_int;
		xmove_start && !xmove_busy && xmove_internal;
	endsequence
	sequence setup_4;
		(xmove_busy && !xmove_strobe) [*4];
	endsequence
	ctrl_top_zero_a: assert property (rd_ckc |=> sfr_rdata[7:6] == 2'h0)
		else $error("clock control top bits read nonzero");
	flag_nibble_a: assert property (rd_flg |=> sfr_rdata[3:0] == 4'h8)
		else $error("flag register low nibble wrong");
	count_write_a: assert property (
		sfr_req.wr && sfr_req.addr == 8'h8b
		|=> timer1_count[7:0] == $past(sfr_req.wdata))
		else $error("timer 1 low byte write lost");
	flags_sticky_a: assert property (!wr_flg |=>
		(ext_irq_flags & $past(ext_irq_flags)) == $past(ext_irq_flags))
		else $error("edge flag cleared without a write");
	oe_from_latch_a: assert property (port1_pin_oe == ~port1_latch)
		else $error("pin drive does not follow latch");
	flash_lock_a: assert property (program_memory_lock |-> !flash_write_allow)
		else $error("flash write allowed while locked");
	increment_gate_a: assert property (timer2_ext_increment |-> port1_latch[0])
		else $error("count pulse with latch bit clear");
	capture_gate_a: assert property (timer2_capture |->
		timer2_trigger_enable && !timer2_autoreload_mode)
		else $error("capture without enable or in reload mode");
	strobe_setup_a: assert property (
		go_ext |-> ##1 setup_4 ##1 xmove_strobe)
		else $error("strobe not after four setup clocks");
	internal_quiet_a: assert property (go_int |->
		##1 (xmove_busy && !xmove_strobe) [*8] ##1 xmove_done)
		else $error("on-chip move strobed or not two cycles");
	done_single_a: assert property (xmove_done |=> !xmove_done)
		else $error("move done wider than one clock");
	reset_state_a: assert property ($fell(srst) |->
		port1_latch == 8'hff && ext_irq_flags == 4'h0)
		else $error("latch or flags wrong after reset");
endmodule : tcp_sfr_bank_props

bind tcp_sfr_bank tcp_sfr_bank_props chk_u (.*);

/* tb/tcp_core_model.sv */
// processor core model driving the special function register bus
module tcp_core_model (
	input  wire logic [7:0]          sfr_rdata,
	input  wire logic                clk_sys,
	output tcp_pkg::tcp_sfr_req_type sfr_req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial sfr_req = '0;
	// =========================================================
	// one access: optional idle clock, then a single-cycle request
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		repeat ($urandom_range(1)) @(posedge clk_sys);
		@(posedge clk_sys);
		#1;
		sfr_req = '{rd: !w, wr: w, addr: a, wdata: d};
		@(posedge clk_sys);
		#1;
		q = sfr_rdata;
		sfr_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : acc
endmodule : tcp_core_model

/* tb/test_timer_clock_port_sfr_bank.sv */
// self-checking bench of the timer, clock and port register bank
module test_timer_clock_port_sfr_bank;
	timeunit 1ns;
	timeprecision 1ps;
	tcp_pkg::tcp_sfr_req_type sfr_req;
	logic [15:0] timer0_count_in, timer1_count_in, timer0_count, timer1_count;
	logic [7:0]  sfr_rdata, port1_pin_out, port1_pin_oe, port1_latch;
	logic [7:0]  pin_drv, q;
	wire  [7:0]  port1_pin_in;
	logic [3:0]  ext_irq_flags;
	logic [2:0]  tk;
	logic        clk_sys, srst, timer0_count_update, timer1_count_update;
	logic        timer0_tick, timer1_tick, timer2_tick, timer2_reload;
	logic        timer2_baud_or_clkout, timer2_trigger_enable;
	logic        timer2_autoreload_mode, timer2_ext_increment;
	logic        timer2_capture, xmove_start, xmove_internal;
	logic        xmove_strobe, xmove_busy, xmove_done, flash_write_allow;
	logic        program_memory_lock, reset_sector_lock, spi_slave_select_n;
	int          failures, compares, n_inc, n_cap, n_rel, k, st, g, tt;
	int          ref_reg [int];
	// open-drain pins: the latch pulls a pin low where its bit is 0
	assign port1_pin_in = pin_drv & ~port1_pin_oe;
	assign tk = {timer2_tick, timer1_tick, timer0_tick};
	tcp_sfr_bank   dut_u  (.*);
	tcp_core_model core_u (.*);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		n_inc <= n_inc + int'(timer2_ext_increment);
		n_cap <= n_cap + int'(timer2_capture);
		n_rel <= n_rel + int'(timer2_reload);
	end
	// =========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			$display("CHECK FAILED at %0t: wait limit reached", $time);
			close_out();
		end
	endtask : bound
	function automatic logic [7:0] expect_rd(input logic [7:0] a);
		if (!ref_reg.exists(a))
			return 8'h00;
		return 8'(ref_reg[a]) & (a == 8'h90 ? pin_drv : 8'hff);
	endfunction : expect_rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		core_u.acc(1'b1, a, d, q);
		if (ref_reg.exists(a)) begin
			ref_reg[a] = d & (a == 8'h8e ? 8'h3f : a == 8'h8f ? 8'h01 :
				a == 8'h91 ? 8'hf0 : 8'hff);
			ref_reg[a] |= (a == 8'h91) ? 8 : 0;
		end
	endtask : wr
	task automatic rd_chk(input logic [7:0] a);
		core_u.acc(1'b0, a, 8'h00, q);
		chk(q, expect_rd(a));
	endtask : rd_chk
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle
	task automatic gap(input int t);
		repeat (3) begin
			g = 0;
			do begin
				@(posedge clk_sys);
				#1;
				g++;
			end while (tk[t] !== 1'b1 && g < 30);
			bound(g, 30);
		end
	endtask : gap
	// =========================================================
	// main sequence
	initial begin
		void'($urandom(42167));
		{srst, timer0_count_update, timer1_count_update} = 3'b100;
		{timer2_baud_or_clkout, timer2_trigger_enable} = 2'b00;
		{timer2_autoreload_mode, xmove_start, xmove_internal} = 3'b000;
		{program_memory_lock, reset_sector_lock} = 2'b00;
		{timer1_count_in, timer0_count_in} = 32'h0;
		pin_drv = 8'hff;
		for (int a = 'h8a; a < 'h92; a++)
			ref_reg[a] = 0;
		ref_reg['h8e] = 'h01;
		ref_reg['h90] = 'hff;
		ref_reg['h91] = 'h08;
		idle(10);
		srst = 1'b0;
		for (int a = 'h89; a < 'h93; a++)
			rd_chk(8'(a));
		chk(port1_latch, 8'hff);
		chk(port1_pin_out, 8'h00);
		$display("test reset values done");
		repeat (3) begin
			for (int a = 'h8a; a < 'h93; a++)
				if (a != 'h90) wr(8'(a), 8'($urandom));
			for (int a = 'h8a; a < 'h93; a++)
				rd_chk(8'(a));
			chk(timer0_count, {ref_reg['h8c][7:0], ref_reg['h8a][7:0]});
			chk(timer1_count, {ref_reg['h8d][7:0], ref_reg['h8b][7:0]});
			chk(ext_irq_flags, ref_reg['h91][7:4]);
		end
		{timer1_count_in, timer0_count_in} = $urandom;
		{timer1_count_update, timer0_count_update} = 2'b11;
		@(posedge clk_sys);
		#1;
		{timer1_count_update, timer0_count_update} = 2'b00;
		ref_reg['h8a] = timer0_count_in[7:0];
		ref_reg['h8c] = timer0_count_in[15:8];
		ref_reg['h8d] = timer1_count_in[15:8];
		ref_reg['h8b] = timer1_count_in[7:0];
		for (int a = 'h8a; a < 'h8e; a++)
			rd_chk(8'(a));
		$display("test count bytes done");
		wr(8'h8f, 8'hff);
		for (int i = 0; i < 4; i++) begin
			{program_memory_lock, reset_sector_lock} = 2'(i);
			@(posedge clk_sys);
			#1;
			chk(flash_write_allow, i == 0);
		end
		{program_memory_lock, reset_sector_lock} = 2'b00;
		wr(8'h8f, 8'h00);
		chk(flash_write_allow, 1'b0);
		$display("test flash select done");
		for (int t = 0; t < 4; t++) begin
			for (int f = 0; f < 2; f++) begin
				tt = (t > 2) ? 2 : t;
				timer2_baud_or_clkout = (t == 3);
				wr(8'h8e, 8'h01 | 8'(f << (3 + tt)));
				gap(tt);
				chk(g, (f == 1 && t < 3) ? 4 : 12);
			end
		end
		timer2_baud_or_clkout = 1'b0;
		$display("test prescale done");
		for (int s = 0; s < 9; s++) begin
			wr(8'h8e, 8'(s));
			xmove_internal = (s == 8);
			xmove_start = 1'b1;
			@(posedge clk_sys);
			#1;
			xmove_start = 1'b0;
			k = 0;
			st = 0;
			do begin
				@(posedge clk_sys);
				#1;
				k++;
				st += int'(xmove_strobe);
				xmove_start = (k == 2);
			end while (xmove_done !== 1'b1 && k < 80);
			bound(k, 80);
			chk(k, s == 8 ? 8 : 4 * (2 + s));
			chk(st, s == 8 ? 0 : s == 0 ? 2 : 4 * s);
		end
		$display("test data move done");
		wr(8'h91, 8'h00);
		pin_drv = 8'h0f;
		idle(8);
		chk(spi_slave_select_n, 1'b0);
		ref_reg['h91] = 'ha8;
		rd_chk(8'h91);
		rd_chk(8'h90);
		wr(8'h91, 8'h00);
		pin_drv = 8'hff;
		idle(8);
		ref_reg['h91] = 'h58;
		rd_chk(8'h91);
		wr(8'h91, 8'hf0);
		chk(ext_irq_flags, 4'hf);
		wr(8'h91, 8'h00);
		wr(8'h90, 8'h0f);
		idle(8);
		rd_chk(8'h91);
		pin_drv = 8'h0f;
		wr(8'h90, 8'hff);
		pin_drv = 8'hff;
		idle(8);
		wr(8'h91, 8'h00);
		$display("test edge flags done");
		timer2_trigger_enable = 1'b1;
		for (int m = 0; m < 3; m++) begin
			timer2_autoreload_mode = (m == 1);
			timer2_trigger_enable = (m < 2);
			pin_drv = 8'hfc;
			idle(8);
			pin_drv = 8'hff;
			idle(8);
			chk(n_inc, m + 1);
			chk(n_cap, 1);
			chk(n_rel, m > 0);
		end
		$display("test timer 2 pins done");
		close_out();
	end
endmodule : test_timer_clock_port_sfr_bank
